// [core/cfo_core.sv]
// cpu status byte, alu flag write-back and operand address stage
`timescale 1ns/1ps
module cfo_core (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic exec_valid_in,
	input wire cfo_pkg::cfo_alu_req_t alu_req_in,
	input wire logic opnd_valid_in,
	input wire cfo_pkg::cfo_opnd_req_t opnd_req_in,
	input wire logic [7:0] wbase_in,
	input wire logic [7:0] wreg_val_in,
	input wire logic [15:0] pair_val_in,
	input wire logic [15:0] next_pc_in,
	input wire logic rf_wr_en_in,
	input wire logic rf_rd_en_in,
	input wire logic [7:0] rf_addr_in,
	input wire logic [7:0] rf_wr_data_in,
	output logic [7:0] status_out,
	output cfo_pkg::cfo_flags_t cond_flags_out,
	output logic [7:0] result_out,
	output logic result_we_out,
	output logic done_out,
	output logic [7:0] rf_rd_data_out,
	output logic rf_rd_hit_out,
	output logic [7:0] reg_addr_out,
	output logic [15:0] eff_addr_out,
	output logic [7:0] imm_out,
	output logic opnd_legal_out,
	output logic opnd_done_out
);
	logic [7:0] status_q;
	logic [7:0] status_d;
	logic [7:0] result_q;
	logic [7:0] result_d;
	logic result_we_q;
	logic done_q;
	logic [7:0] rd_data_q;
	logic [7:0] rd_data_d;
	logic rd_hit_q;
	logic [7:0] reg_addr_q;
	logic [15:0] eff_addr_q;
	logic [7:0] imm_q;
	logic legal_q;
	logic opnd_done_q;

	logic [7:0] alu_res;
	cfo_pkg::cfo_flags_t alu_flags;
	cfo_pkg::cfo_flags_t alu_mask;
	logic alu_wr_res;
	cfo_pkg::cfo_flags_t old_flags;
	cfo_pkg::cfo_flags_t new_flags;
	logic [7:0] upd_mask;
	logic [7:0] upd_bits;
	logic [7:0] sw_base;
	logic hit_status;
	logic sw_write;
	logic sw_read;
	logic flag_upd;

	logic [7:0] opnd_reg_addr;
	logic [15:0] opnd_eff_addr;
	logic [7:0] opnd_imm;
	logic opnd_legal;

	cfo_flag_unit u_flag (
		.req_in(alu_req_in),
		.carry_in(status_q[cfo_pkg::FLAG_C]),
		.res_out(alu_res),
		.flags_out(alu_flags),
		.mask_out(alu_mask),
		.wr_res_out(alu_wr_res)
	);

	cfo_operand_unit u_opnd (
		.req_in(opnd_req_in),
		.wbase_in(wbase_in),
		.wreg_val_in(wreg_val_in),
		.pair_val_in(pair_val_in),
		.next_pc_in(next_pc_in),
		.reg_addr_out(opnd_reg_addr),
		.eff_addr_out(opnd_eff_addr),
		.imm_out(opnd_imm),
		.legal_out(opnd_legal)
	);

	// status byte access decode
	assign hit_status = rf_addr_in == cfo_pkg::STATUS_ADDR;
	assign sw_write = rf_wr_en_in && hit_status;
	assign sw_read = rf_rd_en_in && hit_status;
	assign flag_upd = exec_valid_in && alu_mask != cfo_pkg::NIB_ZERO;

	// software write sets the base value; flags merge over it
	assign sw_base = sw_write ? rf_wr_data_in : status_q;

	assign old_flags = status_q[cfo_pkg::FLAG_C:cfo_pkg::FLAG_V];

	// per flag: take the alu value only where the operation affects it
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_flag
			assign new_flags[gi] = alu_mask[gi] ? alu_flags[gi] : old_flags[gi];
		end
	endgenerate

	// lower nibble never touched by the flag path
	assign upd_mask = {alu_mask, cfo_pkg::NIB_ZERO};
	assign upd_bits = {new_flags, cfo_pkg::NIB_ZERO};

	// flag write-back wins over a same-cycle software write of those bits
	assign status_d = flag_upd ? (sw_base & ~upd_mask) | (upd_bits & upd_mask)
		: sw_base;

	assign result_d = exec_valid_in ? alu_res : result_q;

	// a read in the update cycle returns the old byte
	assign rd_data_d = sw_read ? status_q : rd_data_q;

	// status register
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			status_q <= cfo_pkg::STATUS_RESET;
		end else begin
			status_q <= status_d;
		end
	end

	// result and its write-back strobe
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			result_q <= cfo_pkg::BYTE_ZERO;
		end else begin
			result_q <= result_d;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			result_we_q <= 1'b0;
		end else begin
			result_we_q <= exec_valid_in && alu_wr_res;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			done_q <= 1'b0;
		end else begin
			done_q <= exec_valid_in;
		end
	end

	// register-file read port for the status byte
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_data_q <= cfo_pkg::BYTE_ZERO;
		end else begin
			rd_data_q <= rd_data_d;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_hit_q <= 1'b0;
		end else begin
			rd_hit_q <= sw_read;
		end
	end

	// operand stage: address, immediate and legal outputs hold until the next request; operand done pulses for one cycle
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reg_addr_q <= cfo_pkg::BYTE_ZERO;
		end else if (opnd_valid_in) begin
			reg_addr_q <= opnd_reg_addr;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			eff_addr_q <= cfo_pkg::WORD_ZERO;
		end else if (opnd_valid_in) begin
			eff_addr_q <= opnd_eff_addr;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			imm_q <= cfo_pkg::BYTE_ZERO;
		end else if (opnd_valid_in) begin
			imm_q <= opnd_imm;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			legal_q <= 1'b0;
		end else if (opnd_valid_in) begin
			legal_q <= opnd_legal;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			opnd_done_q <= 1'b0;
		end else begin
			opnd_done_q <= opnd_valid_in;
		end
	end

	assign status_out = status_q;
	// jump test sees only the upper nibble
	assign cond_flags_out = status_q[cfo_pkg::FLAG_C:cfo_pkg::FLAG_V];
	assign result_out = result_q;
	assign result_we_out = result_we_q;
	assign done_out = done_q;
	assign rf_rd_data_out = rd_data_q;
	assign rf_rd_hit_out = rd_hit_q;
	assign reg_addr_out = reg_addr_q;
	assign eff_addr_out = eff_addr_q;
	assign imm_out = imm_q;
	assign opnd_legal_out = legal_q;
	assign opnd_done_out = opnd_done_q;
endmodule : cfo_core

// [inc/cfo_pkg.sv]
// constants and types for the cpu flag and operand unit
// Operation
// - overflow bit 4 set when signed result leaves -128..+127
// - logical operations always clear overflow
// - sign bit 5 copies result msb after arith, logic, rotate, shift
// - zero bit 6 set when arith or logic result is zero
// - bit test, rotate and shift set zero on all-zero result
// - carry bit 7 set on carry out of or borrow into bit 7
// - rotate or shift loads carry with the last bit moved out
// - set, clear and complement carry directly
// - register operand: any of 256 locations or one of 16 working registers
// - register pair: even location up to 254 or even working pair, 16 bits
// - indirect pair: even location or working pair, contents give address
// - indexed: base 0..255 plus working register contents
// - short indexed: signed -128..+127 displacement plus even working pair
// - long indexed: unsigned 0..8191 offset plus even working pair
// - direct address: absolute 13-bit program address 0..8191
// - relative jump: signed -128..+127 added to next instruction address
// - immediate: 8-bit constant 0..255 from instruction stream
// - only upper four status bits go to conditional jump testing
package cfo_pkg;
	localparam int FLAG_V = 4;
	localparam int FLAG_S = 5;
	localparam int FLAG_Z = 6;
	localparam int FLAG_C = 7;
	localparam int MSB = 7;
	localparam logic [7:0] STATUS_ADDR = 8'hD5;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] PAIR_MAX = 8'hFE;
	localparam logic [15:0] PROG_MAX = 16'h1FFF;
	localparam logic [15:0] WORD_ZERO = 16'h0000;
	localparam logic [3:0] NIB_ZERO = 4'h0;
	typedef enum logic [4:0] {
		cfo_op_nop, cfo_op_add, cfo_op_adc, cfo_op_sub, cfo_op_sbc, cfo_op_cp,
		cfo_op_inc, cfo_op_dec, cfo_op_and, cfo_op_or, cfo_op_xor, cfo_op_com,
		cfo_op_tm, cfo_op_tcm, cfo_op_rol, cfo_op_rolc, cfo_op_ror, cfo_op_rorc,
		cfo_op_sra, cfo_op_scf, cfo_op_rcf, cfo_op_ccf
	} cfo_op_t;
	typedef enum logic [3:0] {
		cfo_reg_mode, cfo_wreg_mode, register_pair_operand, working_pair_operand,
		cfo_ind_pair_mode, cfo_indexed_mode, short_indexed_mode, long_indexed_mode,
		direct_address_mode, relative_jump_mode, immediate_mode
	} cfo_mode_t;
	// packed so that c lands on status bit 7 and v on bit 4
	typedef struct packed {
		logic c;
		logic z;
		logic s;
		logic v;
	} cfo_flags_t;
	typedef struct packed {
		cfo_op_t op;
		logic [7:0] a;
		logic [7:0] b;
	} cfo_alu_req_t;
	typedef struct packed {
		cfo_mode_t mode;
		logic [7:0] field;
		logic [7:0] disp;
		logic [15:0] word;
	} cfo_opnd_req_t;
endpackage : cfo_pkg

// [core/cfo_flag_unit.sv]
// result and flag computation for one alu operation
`timescale 1ns/1ps
module cfo_flag_unit (
	input wire cfo_pkg::cfo_alu_req_t req_in,
	input wire logic carry_in,
	output logic [7:0] res_out,
	output cfo_pkg::cfo_flags_t flags_out,
	output cfo_pkg::cfo_flags_t mask_out,
	output logic wr_res_out
);
	logic [8:0] sum;
	logic [7:0] a;
	logic [7:0] b;
	logic cin;
	logic is_sub;
	assign a = req_in.a;
	assign b = req_in.b;
	always_comb begin
		res_out = a;
		flags_out = '0;
		mask_out = '0;
		wr_res_out = 1'b1;
		is_sub = 1'b0;
		cin = 1'b0;
		sum = 9'h000;
		case (req_in.op)
			cfo_pkg::cfo_op_add, cfo_pkg::cfo_op_adc, cfo_pkg::cfo_op_sub,
			cfo_pkg::cfo_op_sbc, cfo_pkg::cfo_op_cp: begin
				is_sub = req_in.op == cfo_pkg::cfo_op_sub || req_in.op == cfo_pkg::cfo_op_sbc
					|| req_in.op == cfo_pkg::cfo_op_cp;
				cin = (req_in.op == cfo_pkg::cfo_op_adc || req_in.op == cfo_pkg::cfo_op_sbc)
					& carry_in;
				// borrow shows as bit 8 of the wrapped difference
				sum = is_sub ? {1'b0, a} - {1'b0, b} - {8'h00, cin}
					: {1'b0, a} + {1'b0, b} + {8'h00, cin};
				res_out = sum[7:0];
				flags_out.c = sum[8];
				flags_out.v = is_sub ? (a[7] ^ b[7]) & (sum[7] ^ a[7])
					: ~(a[7] ^ b[7]) & (sum[7] ^ a[7]);
				mask_out = 4'hF;
				wr_res_out = req_in.op != cfo_pkg::cfo_op_cp;
			end
			cfo_pkg::cfo_op_inc, cfo_pkg::cfo_op_dec: begin
				res_out = req_in.op == cfo_pkg::cfo_op_inc ? a + 8'h01 : a - 8'h01;
				flags_out.v = req_in.op == cfo_pkg::cfo_op_inc ? a == 8'h7F : a == 8'h80;
				mask_out = 4'h7;
			end
			cfo_pkg::cfo_op_and, cfo_pkg::cfo_op_or, cfo_pkg::cfo_op_xor,
			cfo_pkg::cfo_op_com: begin
				res_out = req_in.op == cfo_pkg::cfo_op_and ? a & b
					: req_in.op == cfo_pkg::cfo_op_or ? a | b
					: req_in.op == cfo_pkg::cfo_op_xor ? a ^ b : ~a;
				flags_out.v = 1'b0;
				mask_out = 4'h7;
			end
			cfo_pkg::cfo_op_tm, cfo_pkg::cfo_op_tcm: begin
				res_out = req_in.op == cfo_pkg::cfo_op_tm ? a & b : ~a & b;
				flags_out.v = 1'b0;
				mask_out = 4'h7;
				wr_res_out = 1'b0;
			end
			cfo_pkg::cfo_op_rol, cfo_pkg::cfo_op_rolc: begin
				res_out = {a[6:0], req_in.op == cfo_pkg::cfo_op_rol ? a[7] : carry_in};
				flags_out.c = a[7];
				flags_out.v = a[7] ^ a[6];
				mask_out = 4'hF;
			end
			cfo_pkg::cfo_op_ror, cfo_pkg::cfo_op_rorc, cfo_pkg::cfo_op_sra: begin
				res_out = {req_in.op == cfo_pkg::cfo_op_ror ? a[0]
					: req_in.op == cfo_pkg::cfo_op_rorc ? carry_in : a[7], a[7:1]};
				flags_out.c = a[0];
				// msb change; through carry the new msb is the old carry
				flags_out.v = req_in.op == cfo_pkg::cfo_op_sra ? 1'b0
					: res_out[cfo_pkg::MSB] ^ a[cfo_pkg::MSB];
				mask_out = 4'hF;
			end
			cfo_pkg::cfo_op_scf, cfo_pkg::cfo_op_rcf, cfo_pkg::cfo_op_ccf: begin
				flags_out.c = req_in.op == cfo_pkg::cfo_op_scf ? 1'b1
					: req_in.op == cfo_pkg::cfo_op_rcf ? 1'b0 : ~carry_in;
				mask_out = 4'h8;
				wr_res_out = 1'b0;
			end
			default: begin
				wr_res_out = 1'b0;
			end
		endcase
		flags_out.s = res_out[cfo_pkg::MSB];
		flags_out.z = res_out == cfo_pkg::BYTE_ZERO;
	end
endmodule : cfo_flag_unit

// [core/cfo_operand_unit.sv]
// operand range check and address formation per addressing mode
`timescale 1ns/1ps
module cfo_operand_unit (
	input wire cfo_pkg::cfo_opnd_req_t req_in,
	input wire logic [7:0] wbase_in,
	input wire logic [7:0] wreg_val_in,
	input wire logic [15:0] pair_val_in,
	input wire logic [15:0] next_pc_in,
	output logic [7:0] reg_addr_out,
	output logic [15:0] eff_addr_out,
	output logic [7:0] imm_out,
	output logic legal_out
);
	logic [3:0] wn;
	logic [7:0] waddr;
	logic [15:0] disp_sx;
	logic even_field;
	logic even_wpair;
	assign wn = req_in.field[3:0];
	assign waddr = {wbase_in[7:4], wn};
	assign disp_sx = {{8{req_in.disp[7]}}, req_in.disp};
	assign even_field = ~req_in.field[0] && req_in.field <= cfo_pkg::PAIR_MAX;
	assign even_wpair = ~wn[0];
	always_comb begin
		reg_addr_out = req_in.field;
		eff_addr_out = cfo_pkg::WORD_ZERO;
		imm_out = cfo_pkg::BYTE_ZERO;
		legal_out = 1'b1;
		case (req_in.mode)
			cfo_pkg::cfo_reg_mode: reg_addr_out = req_in.field;
			cfo_pkg::cfo_wreg_mode: reg_addr_out = waddr;
			cfo_pkg::register_pair_operand: begin
				legal_out = even_field;
				eff_addr_out = pair_val_in;
			end
			cfo_pkg::working_pair_operand: begin
				reg_addr_out = waddr;
				legal_out = even_wpair;
				eff_addr_out = pair_val_in;
			end
			cfo_pkg::cfo_ind_pair_mode: begin
				// disp bit 0 picks working pair over location
				reg_addr_out = req_in.disp[0] ? waddr : req_in.field;
				legal_out = req_in.disp[0] ? even_wpair : even_field;
				eff_addr_out = pair_val_in;
			end
			cfo_pkg::cfo_indexed_mode: begin
				reg_addr_out = req_in.disp + wreg_val_in;
			end
			cfo_pkg::short_indexed_mode: begin
				reg_addr_out = waddr;
				legal_out = even_wpair;
				eff_addr_out = pair_val_in + disp_sx;
			end
			cfo_pkg::long_indexed_mode: begin
				reg_addr_out = waddr;
				legal_out = even_wpair && req_in.word <= cfo_pkg::PROG_MAX;
				eff_addr_out = pair_val_in + req_in.word;
			end
			cfo_pkg::direct_address_mode: begin
				legal_out = req_in.word <= cfo_pkg::PROG_MAX;
				eff_addr_out = req_in.word & cfo_pkg::PROG_MAX;
			end
			cfo_pkg::relative_jump_mode: begin
				eff_addr_out = next_pc_in + disp_sx;
			end
			cfo_pkg::immediate_mode: begin
				imm_out = req_in.field;
			end
			default: legal_out = 1'b0;
		endcase
	end
endmodule : cfo_operand_unit

// [tb/cfo_core_asserts.sv]
// property checker for the cpu flag and operand core
`timescale 1ns/1ps
module cfo_core_asserts (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic exec_valid_in,
	input wire cfo_pkg::cfo_alu_req_t alu_req_in,
	input wire logic opnd_valid_in,
	input wire cfo_pkg::cfo_opnd_req_t opnd_req_in,
	input wire logic rf_wr_en_in,
	input wire logic [7:0] status_out,
	input wire cfo_pkg::cfo_flags_t cond_flags_out,
	input wire logic [7:0] result_out,
	input wire logic done_out,
	input wire logic [15:0] eff_addr_out,
	input wire logic opnd_legal_out,
	input wire logic opnd_done_out
);
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!rst_n_in);
	property p_done;
		exec_valid_in |=> done_out ##1 (done_out == $past(exec_valid_in));
	endproperty
	a_done: assert property (p_done) else $error("done pulse missing");
	property p_opnd;
		opnd_done_out == $past(opnd_valid_in);
	endproperty
	a_opnd: assert property (p_opnd) else $error("operand done mistimed");
	property p_cond;
		done_out |-> cond_flags_out == status_out[7:4];
	endproperty
	a_cond: assert property (p_cond) else $error("jump flags differ");
	property p_lo;
		done_out && !$past(rf_wr_en_in) && !$past(rf_wr_en_in, 2)
			|-> status_out[3:0] == $past(status_out[3:0]);
	endproperty
	a_lo: assert property (p_lo) else $error("low status bits changed");
	property p_zero;
		done_out && $past(alu_req_in.op) inside {cfo_pkg::cfo_op_add, cfo_pkg::cfo_op_and}
			|-> status_out[6] == (result_out == 8'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");
	property p_sign;
		done_out && $past(alu_req_in.op) inside {cfo_pkg::cfo_op_sub, cfo_pkg::cfo_op_sra}
			|-> status_out[5] == result_out[7];
	endproperty
	a_sign: assert property (p_sign) else $error("sign flag wrong");
	property p_logv;
		done_out && $past(alu_req_in.op) inside {cfo_pkg::cfo_op_or, cfo_pkg::cfo_op_xor}
			|-> !status_out[4];
	endproperty
	a_logv: assert property (p_logv) else $error("overflow after logic");
	property p_addc;
		done_out && $past(alu_req_in.op) == cfo_pkg::cfo_op_add
			|-> status_out[7] == (result_out < $past(alu_req_in.a));
	endproperty
	a_addc: assert property (p_addc) else $error("add carry wrong");
	property p_addv;
		done_out && $past(alu_req_in.op) == cfo_pkg::cfo_op_add |-> status_out[4] ==
			($past(alu_req_in.a[7]) == $past(alu_req_in.b[7]) && result_out[7] != $past(alu_req_in.a[7]));
	endproperty
	a_addv: assert property (p_addv) else $error("add overflow wrong");
	property p_rolc;
		done_out && $past(alu_req_in.op) == cfo_pkg::cfo_op_rol
			|-> status_out[7] == $past(alu_req_in.a[7]);
	endproperty
	a_rolc: assert property (p_rolc) else $error("rotate carry wrong");
	property p_scf;
		done_out && $past(alu_req_in.op) == cfo_pkg::cfo_op_scf |-> status_out[7];
	endproperty
	a_scf: assert property (p_scf) else $error("carry not set");
	property p_dir;
		opnd_done_out && $past(opnd_req_in.mode) == cfo_pkg::direct_address_mode
			|-> opnd_legal_out == ($past(opnd_req_in.word) <= 16'h1FFF);
	endproperty
	a_dir: assert property (p_dir) else $error("direct range wrong");
endmodule : cfo_core_asserts

bind cfo_core cfo_core_asserts u_asserts (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
	.exec_valid_in(exec_valid_in), .alu_req_in(alu_req_in), .opnd_valid_in(opnd_valid_in),
	.opnd_req_in(opnd_req_in), .rf_wr_en_in(rf_wr_en_in), .status_out(status_out),
	.cond_flags_out(cond_flags_out), .result_out(result_out), .done_out(done_out),
	.eff_addr_out(eff_addr_out), .opnd_legal_out(opnd_legal_out), .opnd_done_out(opnd_done_out));

// [tb/tb.sv]
// self-checking bench for the cpu flag and operand core
`timescale 1ns/1ps
module tb;
	logic sys_clk_in, rst_n_in, exec_valid_in, opnd_valid_in, rf_wr_en_in, rf_rd_en_in;
	cfo_pkg::cfo_alu_req_t alu_req_in;
	cfo_pkg::cfo_opnd_req_t opnd_req_in;
	cfo_pkg::cfo_flags_t cond_flags_out;
	logic [7:0] wbase_in, wreg_val_in, rf_addr_in, rf_wr_data_in, status_out, result_out;
	logic [7:0] rf_rd_data_out, reg_addr_out, imm_out;
	logic [15:0] pair_val_in, next_pc_in, eff_addr_out;
	logic result_we_out, done_out, rf_rd_hit_out, opnd_legal_out, opnd_done_out;
	logic [3:0] lo_nib;
	int fail_count, comparisons;
	cfo_core DUT (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .exec_valid_in(exec_valid_in),
		.alu_req_in(alu_req_in), .opnd_valid_in(opnd_valid_in), .opnd_req_in(opnd_req_in),
		.wbase_in(wbase_in), .wreg_val_in(wreg_val_in), .pair_val_in(pair_val_in),
		.next_pc_in(next_pc_in), .rf_wr_en_in(rf_wr_en_in), .rf_rd_en_in(rf_rd_en_in),
		.rf_addr_in(rf_addr_in), .rf_wr_data_in(rf_wr_data_in), .status_out(status_out),
		.cond_flags_out(cond_flags_out), .result_out(result_out), .result_we_out(result_we_out),
		.done_out(done_out), .rf_rd_data_out(rf_rd_data_out), .rf_rd_hit_out(rf_rd_hit_out),
		.reg_addr_out(reg_addr_out), .eff_addr_out(eff_addr_out), .imm_out(imm_out),
		.opnd_legal_out(opnd_legal_out), .opnd_done_out(opnd_done_out));
	initial begin
		sys_clk_in = 1'b0;
		forever #50 sys_clk_in = ~sys_clk_in;
	end
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : give_verdict
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// bounded wait for a one-cycle pulse: 0 done, 1 operand done, 2 read hit
	task automatic wait_for(input int which);
		int n;
		logic seen;
		n = 0;
		#1;
		seen = which == 0 ? done_out : which == 1 ? opnd_done_out : rf_rd_hit_out;
		while (seen !== 1'b1 && n < 4) begin
			@(posedge sys_clk_in);
			#1;
			n++;
			seen = which == 0 ? done_out : which == 1 ? opnd_done_out : rf_rd_hit_out;
		end
		if (seen !== 1'b1) begin
			fail_count++;
			give_verdict();
		end
	endtask : wait_for
	task automatic alu(input cfo_pkg::cfo_op_t op, input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] res, input logic [3:0] fl, input logic we);
		@(posedge sys_clk_in);
		alu_req_in <= '{op, a, b};
		exec_valid_in <= 1'b1;
		@(posedge sys_clk_in);
		exec_valid_in <= 1'b0;
		wait_for(0);
		chk("result_we", {15'h0000, we}, {15'h0000, result_we_out});
		if (we) chk("result", {8'h00, res}, {8'h00, result_out});
		chk("status", {8'h00, fl, lo_nib}, {8'h00, status_out});
		chk("cond_flags", {12'h000, fl}, {12'h000, cond_flags_out});
	endtask : alu
	task automatic rf(input logic wr, input logic [7:0] addr, input logic [7:0] data, input logic hit);
		@(posedge sys_clk_in);
		rf_addr_in <= addr;
		rf_wr_data_in <= data;
		rf_wr_en_in <= wr;
		rf_rd_en_in <= !wr;
		@(posedge sys_clk_in);
		rf_wr_en_in <= 1'b0;
		rf_rd_en_in <= 1'b0;
		if (wr) begin
			@(posedge sys_clk_in);
		end else if (hit) begin
			wait_for(2);
			chk("rd_data", {8'h00, data}, {8'h00, rf_rd_data_out});
		end else begin
			#1;
			chk("rd_hit", 16'h0000, {15'h0000, rf_rd_hit_out});
		end
	endtask : rf
	// use_eff picks eff_addr or reg_addr; lg 2 leaves legality unchecked
	task automatic opd(input cfo_pkg::cfo_mode_t mode, input logic [7:0] field,
		input logic [7:0] disp, input logic [15:0] word, input logic [15:0] exp,
		input logic use_eff, input int lg);
		@(posedge sys_clk_in);
		opnd_req_in <= '{mode, field, disp, word};
		opnd_valid_in <= 1'b1;
		@(posedge sys_clk_in);
		opnd_valid_in <= 1'b0;
		wait_for(1);
		if (lg != 2) chk("legal", lg[15:0], {15'h0000, opnd_legal_out});
		if (use_eff && lg != 0) chk("eff_addr", exp, eff_addr_out);
		if (!use_eff) chk("reg_addr", exp, {8'h00, reg_addr_out});
		chk("imm", (mode == cfo_pkg::immediate_mode) ? {8'h00, field} : 16'h0000,
			{8'h00, imm_out});
	endtask : opd
	task automatic t_bus();
		rf(1'b0, 8'hD5, 8'h00, 1'b1);
		rf(1'b1, 8'hD5, 8'h05, 1'b1);
		rf(1'b1, 8'hD4, 8'hFF, 1'b0);
		rf(1'b0, 8'hD5, 8'h05, 1'b1);
		rf(1'b0, 8'hD4, 8'h00, 1'b0);
		lo_nib = 4'h5;
		$display("test status bus done");
	endtask : t_bus
	task automatic t_arith();
		alu(cfo_pkg::cfo_op_add, 8'h7F, 8'h01, 8'h80, 4'h3, 1'b1);
		alu(cfo_pkg::cfo_op_add, 8'hFF, 8'h01, 8'h00, 4'hC, 1'b1);
		alu(cfo_pkg::cfo_op_sub, 8'h80, 8'h01, 8'h7F, 4'h1, 1'b1);
		alu(cfo_pkg::cfo_op_sub, 8'h00, 8'h01, 8'hFF, 4'hA, 1'b1);
		alu(cfo_pkg::cfo_op_adc, 8'h01, 8'h01, 8'h03, 4'h0, 1'b1);
		alu(cfo_pkg::cfo_op_cp, 8'h05, 8'h05, 8'h00, 4'h4, 1'b0);
		alu(cfo_pkg::cfo_op_inc, 8'h7F, 8'h00, 8'h80, 4'h3, 1'b1);
		alu(cfo_pkg::cfo_op_scf, 8'h00, 8'h00, 8'h00, 4'hB, 1'b0);
		alu(cfo_pkg::cfo_op_sbc, 8'h10, 8'h01, 8'h0E, 4'h0, 1'b1);
		alu(cfo_pkg::cfo_op_dec, 8'h80, 8'h00, 8'h7F, 4'h1, 1'b1);
		$display("test arithmetic flags done");
	endtask : t_arith
	task automatic t_logic();
		alu(cfo_pkg::cfo_op_add, 8'h80, 8'h80, 8'h00, 4'hD, 1'b1);
		alu(cfo_pkg::cfo_op_and, 8'hF0, 8'h0F, 8'h00, 4'hC, 1'b1);
		alu(cfo_pkg::cfo_op_or, 8'h80, 8'h01, 8'h81, 4'hA, 1'b1);
		alu(cfo_pkg::cfo_op_xor, 8'hFF, 8'hFF, 8'h00, 4'hC, 1'b1);
		alu(cfo_pkg::cfo_op_com, 8'h00, 8'h00, 8'hFF, 4'hA, 1'b1);
		alu(cfo_pkg::cfo_op_tm, 8'hF0, 8'h0F, 8'h00, 4'hC, 1'b0);
		alu(cfo_pkg::cfo_op_tcm, 8'hF0, 8'h0F, 8'h00, 4'h8, 1'b0);
		$display("test logic flags done");
	endtask : t_logic
	task automatic t_rot();
		alu(cfo_pkg::cfo_op_rcf, 8'h00, 8'h00, 8'h00, 4'h0, 1'b0);
		alu(cfo_pkg::cfo_op_rol, 8'h80, 8'h00, 8'h01, 4'h9, 1'b1);
		alu(cfo_pkg::cfo_op_rolc, 8'h80, 8'h00, 8'h01, 4'h9, 1'b1);
		alu(cfo_pkg::cfo_op_ror, 8'h01, 8'h00, 8'h80, 4'hB, 1'b1);
		alu(cfo_pkg::cfo_op_rorc, 8'h00, 8'h00, 8'h80, 4'h3, 1'b1);
		alu(cfo_pkg::cfo_op_sra, 8'h01, 8'h00, 8'h00, 4'hC, 1'b1);
		alu(cfo_pkg::cfo_op_sra, 8'h81, 8'h00, 8'hC0, 4'hA, 1'b1);
		alu(cfo_pkg::cfo_op_ccf, 8'h00, 8'h00, 8'h00, 4'h2, 1'b0);
		alu(cfo_pkg::cfo_op_scf, 8'h00, 8'h00, 8'h00, 4'hA, 1'b0);
		alu(cfo_pkg::cfo_op_nop, 8'h00, 8'h00, 8'h00, 4'hA, 1'b0);
		$display("test rotate and carry done");
	endtask : t_rot
	task automatic t_opnd();
		opd(cfo_pkg::cfo_reg_mode, 8'hFF, 8'h00, 16'h0000, 16'h00FF, 1'b0, 2);
		opd(cfo_pkg::cfo_wreg_mode, 8'h0F, 8'h00, 16'h0000, 16'h003F, 1'b0, 2);
		opd(cfo_pkg::register_pair_operand, 8'hFE, 8'h00, 16'h0, 16'h1234, 1'b1, 1);
		opd(cfo_pkg::register_pair_operand, 8'hFF, 8'h00, 16'h0, 16'h0, 1'b1, 0);
		opd(cfo_pkg::working_pair_operand, 8'h0E, 8'h00, 16'h0, 16'h1234, 1'b1, 1);
		opd(cfo_pkg::working_pair_operand, 8'h03, 8'h00, 16'h0, 16'h0, 1'b1, 0);
		opd(cfo_pkg::cfo_ind_pair_mode, 8'h20, 8'h00, 16'h0, 16'h1234, 1'b1, 1);
		opd(cfo_pkg::cfo_ind_pair_mode, 8'h05, 8'h01, 16'h0, 16'h0, 1'b1, 0);
		opd(cfo_pkg::cfo_indexed_mode, 8'h00, 8'hFE, 16'h0, 16'h0003, 1'b0, 2);
		opd(cfo_pkg::short_indexed_mode, 8'h04, 8'h80, 16'h0, 16'h11B4, 1'b1, 1);
		opd(cfo_pkg::long_indexed_mode, 8'h02, 8'h00, 16'h1FFF, 16'h3233, 1'b1, 1);
		opd(cfo_pkg::long_indexed_mode, 8'h02, 8'h00, 16'h2000, 16'h0, 1'b1, 0);
		opd(cfo_pkg::direct_address_mode, 8'h00, 8'h00, 16'h1FFF, 16'h1FFF, 1'b1, 1);
		opd(cfo_pkg::direct_address_mode, 8'h00, 8'h00, 16'h2000, 16'h0, 1'b1, 0);
		opd(cfo_pkg::relative_jump_mode, 8'h00, 8'h7F, 16'h0, 16'h027F, 1'b1, 2);
		opd(cfo_pkg::relative_jump_mode, 8'h00, 8'h80, 16'h0, 16'h0180, 1'b1, 2);
		opd(cfo_pkg::immediate_mode, 8'hA5, 8'h00, 16'h0, 16'h00A5, 1'b0, 2);
		$display("test operand forms done");
	endtask : t_opnd
	initial begin
		rst_n_in = 1'b0;
		exec_valid_in = 1'b0;
		opnd_valid_in = 1'b0;
		rf_wr_en_in = 1'b0;
		rf_rd_en_in = 1'b0;
		alu_req_in = '0;
		opnd_req_in = '0;
		rf_addr_in = 8'h00;
		rf_wr_data_in = 8'h00;
		wbase_in = 8'h3A;
		wreg_val_in = 8'h05;
		pair_val_in = 16'h1234;
		next_pc_in = 16'h0200;
		lo_nib = 4'h0;
		fail_count = 0;
		comparisons = 0;
		repeat (3) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		t_bus();
		t_arith();
		t_logic();
		t_rot();
		t_opnd();
		give_verdict();
	end
endmodule : tb
